//--- include/cpurf_pkg.sv
`default_nettype none
package cpurf_pkg;
  // Condition flag bit positions, mask at the top
  localparam int CF_MASK = 7;
  localparam int CF_USER_HI = 6;
  localparam int CF_HALF = 5;
  localparam int CF_USER_LO = 4;
  localparam int CF_NEG = 3;
  localparam int CF_ZERO = 2;
  localparam int CF_OVF = 1;
  localparam int CF_CARRY = 0;

  // Flags after reset: mask set, the rest cleared
  localparam logic [7:0] FLAGS_RESET = 8'h80;

  // Stack moves one word per push or pop
  localparam logic [15:0] SP_STEP = 16'h0002;
  // Fetch advances one word; bit 0 is never stored
  localparam logic [15:0] FETCH_BYTES = 16'h0002;
  localparam logic [14:0] IP_STEP = 15'h0001;
  // General register that doubles as stack pointer
  localparam logic [2:0] SP_INDEX = 3'h7;

  // Operand masks for the half-carry chains
  localparam logic [15:0] HALF_MASK_B = 16'h000F;
  localparam logic [15:0] HALF_MASK_W = 16'h0FFF;
  // Packed decimal limits and correction
  localparam logic [7:0] BCD_LIMIT_B = 8'h99;
  localparam logic [3:0] BCD_LIMIT_N = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;

  // Register access size
  typedef enum logic [1:0] {SZ_WORD, SZ_HIGH, SZ_LOW} cpurf_size_t;

  // Direct operations on the flag register
  typedef enum logic [2:0] {
    FLAGS_IDLE, LOAD_FLAGS_OP, STORE_FLAGS_OP,
    AND_FLAGS_OP, OR_FLAGS_OP, XOR_FLAGS_OP
  } cpurf_fop_t;

  // Flag-producing operations
  typedef enum logic [4:0] {
    ALU_ADD_B, ALU_ADDX_B, ALU_SUB_B, ALU_SUBX_B, ALU_NEG_B,
    ALU_CMP_B, ALU_ADD_W, ALU_SUB_W, ALU_CMP_W, ALU_SHL_B,
    ALU_SHR_B, ALU_MOVE_B, ALU_MOVE_W, BIT_LOAD, BIT_AND,
    BIT_OR, BIT_XOR, BIT_STORE, DECIMAL_ADJUST_ADD,
    DECIMAL_ADJUST_SUB
  } cpurf_alu_t;

  // Branch conditions
  typedef enum logic [3:0] {
    COND_ALWAYS, COND_NEVER, COND_HI, COND_LS, COND_CC, COND_CS,
    COND_NE, COND_EQ, COND_VC, COND_VS, COND_PL, COND_MI,
    COND_GE, COND_LT, COND_GT, COND_LE
  } cpurf_cond_t;
endpackage
`default_nettype wire

//--- hw/cpurf_flag_calc.sv
`timescale 1ns/10ps
`default_nettype none
module cpurf_flag_calc
(
  // Operation and operands
  input wire cpurf_pkg::cpurf_alu_t op,
  input wire logic [15:0] opa,
  input wire logic [15:0] opb,
  input wire logic [2:0] bit_sel,
  // Present flags and the outcome
  input wire logic [7:0] flags_in,
  output logic [15:0] result,
  output logic [7:0] flags_out
);
  import cpurf_pkg::*;

  // Add or subtract with carry/borrow, zero-extended to 17 bits
  function automatic logic [16:0] arith(input logic [15:0] a,
    input logic [15:0] b, input logic cin, input logic sub);
    if (sub)
      arith = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
    else
      arith = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
  endfunction

  // Operation class decode
  wire logic is_sub;
  wire logic is_word;
  wire logic is_neg;
  wire logic cin;
  assign is_sub = op inside {ALU_SUB_B, ALU_SUBX_B, ALU_NEG_B,
    ALU_CMP_B, ALU_SUB_W, ALU_CMP_W};
  assign is_word = op inside {ALU_ADD_W, ALU_SUB_W, ALU_CMP_W};
  assign is_neg = (op == ALU_NEG_B);
  assign cin = (op inside {ALU_ADDX_B, ALU_SUBX_B}) &
    flags_in[CF_CARRY];

  // Operands sized to byte or word; negate is zero minus operand
  wire logic [15:0] a_eff;
  wire logic [15:0] b_eff;
  wire logic [15:0] half_mask;
  assign a_eff = is_neg ? 16'h0000 :
    (is_word ? opa : {8'h00, opa[7:0]});
  assign b_eff = is_neg ? {8'h00, opa[7:0]} :
    (is_word ? opb : {8'h00, opb[7:0]});
  assign half_mask = is_word ? HALF_MASK_W : HALF_MASK_B;

  // Main and nibble chains share the same adder function
  wire logic [16:0] sum;
  wire logic [16:0] half_sum;
  wire logic half_c;
  wire logic carry_c;
  wire logic sa;
  wire logic sb;
  wire logic sr;
  wire logic ovf;
  assign sum = arith(a_eff, b_eff, cin, is_sub);
  assign half_sum = arith(a_eff & half_mask, b_eff & half_mask,
    cin, is_sub);
  assign half_c = is_word ? half_sum[12] : half_sum[4];
  assign carry_c = is_word ? sum[16] : sum[8];
  assign sa = is_word ? a_eff[15] : a_eff[7];
  assign sb = is_word ? b_eff[15] : b_eff[7];
  assign sr = is_word ? sum[15] : sum[7];
  // Signed overflow: like signs in for add, unlike for subtract, result sign other than a
  assign ovf = is_sub ? ((sa != sb) && (sr != sa)) :
    ((sa == sb) && (sr != sa));

  // Bit selection inside the low byte, index 0 to 7
  wire logic [7:0] byte_a;
  wire logic bit_val;
  wire logic [7:0] sel_mask;
  assign byte_a = opa[7:0];
  assign bit_val = byte_a[bit_sel];
  assign sel_mask = 8'h01 << bit_sel;

  // Packed decimal correction, one digit per nibble
  wire logic adj_lo;
  wire logic adj_hi;
  wire logic [7:0] daa_adj;
  wire logic [7:0] das_adj;
  assign adj_lo = flags_in[CF_HALF] | (byte_a[3:0] > BCD_LIMIT_N);
  assign adj_hi = flags_in[CF_CARRY] | (byte_a > BCD_LIMIT_B);
  assign daa_adj = {adj_hi ? BCD_FIX : 4'h0,
    adj_lo ? BCD_FIX : 4'h0};
  assign das_adj = {flags_in[CF_CARRY] ? BCD_FIX : 4'h0,
    flags_in[CF_HALF] ? BCD_FIX : 4'h0};

  // Result and flag selection; user bits and mask pass through
  always_comb
  begin
    logic nz_upd;
    nz_upd = 1'b1;
    flags_out = flags_in;
    result = 16'h0000;
    case (op)
      ALU_ADD_B, ALU_ADDX_B, ALU_SUB_B, ALU_SUBX_B, ALU_NEG_B,
      ALU_CMP_B, ALU_ADD_W, ALU_SUB_W, ALU_CMP_W:
      begin
        result = sum[15:0];
        flags_out[CF_HALF] = half_c;
        flags_out[CF_OVF] = ovf;
        flags_out[CF_CARRY] = carry_c;
      end
      ALU_SHL_B:
      begin
        result = {8'h00, byte_a[6:0], 1'b0};
        flags_out[CF_OVF] = 1'b0;
        flags_out[CF_CARRY] = byte_a[7];
      end
      ALU_SHR_B:
      begin
        result = {8'h00, 1'b0, byte_a[7:1]};
        flags_out[CF_OVF] = 1'b0;
        flags_out[CF_CARRY] = byte_a[0];
      end
      ALU_MOVE_B, ALU_MOVE_W:
      begin
        result = (op == ALU_MOVE_W) ? opa : {8'h00, byte_a};
        flags_out[CF_OVF] = 1'b0;
      end
      // Carry acts as a one-bit accumulator
      BIT_LOAD, BIT_AND, BIT_OR, BIT_XOR:
      begin
        nz_upd = 1'b0;
        result = {8'h00, byte_a};
        case (op)
          BIT_LOAD: flags_out[CF_CARRY] = bit_val;
          BIT_AND: flags_out[CF_CARRY] &= bit_val;
          BIT_OR: flags_out[CF_CARRY] |= bit_val;
          default: flags_out[CF_CARRY] ^= bit_val;
        endcase
      end
      BIT_STORE:
      begin
        nz_upd = 1'b0;
        result = {8'h00, flags_in[CF_CARRY] ? (byte_a | sel_mask) :
          (byte_a & ~sel_mask)};
      end
      DECIMAL_ADJUST_ADD:
      begin
        result = {8'h00, byte_a + daa_adj};
        flags_out[CF_CARRY] = adj_hi;
      end
      DECIMAL_ADJUST_SUB:
      begin
        result = {8'h00, byte_a - das_adj};
      end
      default:
        nz_upd = 1'b0;
    endcase
    // Sign and zero follow the result's own width
    if (nz_upd)
    begin
      flags_out[CF_NEG] = (op inside {ALU_ADD_W, ALU_SUB_W, ALU_CMP_W,
        ALU_MOVE_W}) ? result[15] : result[7];
      flags_out[CF_ZERO] = (op inside {ALU_ADD_W, ALU_SUB_W, ALU_CMP_W,
        ALU_MOVE_W}) ? (result == 16'h0000) :
        (result[7:0] == 8'h00);
    end
  end
endmodule // cpurf_flag_calc
`default_nettype wire

//--- hw/cpurf_reg_file.sv
`timescale 1ns/10ps
`default_nettype none
module cpurf_reg_file
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Start address fetched from the vector table
  input wire logic [15:0] reset_vector,
  // Address read port, always full word
  input wire logic [2:0] addr_sel,
  output logic [15:0] addr_value,
  // Data read port
  input wire logic [2:0] rd_sel,
  input wire cpurf_pkg::cpurf_size_t rd_size,
  output logic [15:0] rd_data,
  // Write port, byte data in the low lane
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire cpurf_pkg::cpurf_size_t wr_size,
  input wire logic [15:0] wr_data,
  // Stack pointer adjust
  input wire logic sp_push,
  input wire logic sp_pop,
  output logic [15:0] stack_top_pointer,
  // Program counter
  input wire logic ip_load,
  input wire logic [15:0] ip_value,
  input wire logic ip_step,
  output logic [15:0] instruction_pointer,
  // Interrupt gating
  input wire logic irq_req,
  input wire logic nmi_req,
  input wire logic irq_start,
  output logic irq_take,
  // Flag register access
  input wire cpurf_pkg::cpurf_fop_t flag_op,
  input wire logic [7:0] flag_operand,
  output logic [7:0] condition_flags,
  // Flag-producing operation
  input wire logic alu_en,
  input wire cpurf_pkg::cpurf_alu_t alu_op,
  input wire logic [15:0] alu_a,
  input wire logic [15:0] alu_b,
  input wire logic [2:0] alu_bit,
  output logic [15:0] alu_result,
  // Branch condition test
  input wire cpurf_pkg::cpurf_cond_t cond_code,
  output logic cond_true
);
  import cpurf_pkg::*;

  // General registers; no reset, software sets them up
  logic [15:0] gpr [8];
  // Program counter keeps only bits 15..1
  logic [14:0] ip_word;
  // Flag register
  logic [7:0] flags;
  logic [7:0] next_flags;
  // Outcome of the flag calculator
  logic [15:0] calc_result;
  logic [7:0] calc_flags;

  // Byte merge for partial writes
  wire logic [15:0] wr_old;
  wire logic [15:0] next_wr_word;
  assign wr_old = gpr[wr_sel];
  assign next_wr_word = (wr_size == SZ_HIGH) ?
    {wr_data[7:0], wr_old[7:0]} :
    (wr_size == SZ_LOW) ? {wr_old[15:8], wr_data[7:0]} :
    wr_data;

  // Stack adjust; an explicit write to R7 wins over it
  wire logic [15:0] sp_now;
  wire logic sp_adj;
  wire logic [15:0] next_sp;
  assign sp_now = gpr[SP_INDEX];
  assign sp_adj = (sp_push ^ sp_pop) &&
    !(wr_en && (wr_sel == SP_INDEX));
  assign next_sp = sp_push ? (sp_now - SP_STEP) :
    (sp_now + SP_STEP);
  assign stack_top_pointer = sp_now;

  // Register array write; sp_adj never targets the written entry
  always_ff @(posedge clk)
  begin
    if (wr_en)
      gpr[wr_sel] <= next_wr_word;
    if (sp_adj)
      gpr[SP_INDEX] <= next_sp;
  end

  // Byte views for the data read port
  wire logic [15:0] rd_word;
  wire logic [15:0] rd_view;
  assign rd_word = gpr[rd_sel];
  assign rd_view = (rd_size == SZ_HIGH) ? {8'h00, rd_word[15:8]} :
    (rd_size == SZ_LOW) ? {8'h00, rd_word[7:0]} : rd_word;

  // Registered reads; a same-cycle write is seen a cycle later
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      addr_value <= 16'h0000;
      rd_data <= 16'h0000;
    end
    else
    begin
      addr_value <= gpr[addr_sel];
      rd_data <= rd_view;
    end
  end

  // Program counter: vector on reset, then load or step
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ip_word <= reset_vector[15:1];
    else if (ip_load)
      ip_word <= ip_value[15:1];
    else if (ip_step)
      ip_word <= ip_word + IP_STEP;
  end
  // Odd targets fall back to the even word below
  assign instruction_pointer = {ip_word, 1'b0};

  // Flag calculator
  cpurf_flag_calc u_calc
  (
    .op(alu_op),
    .opa(alu_a),
    .opb(alu_b),
    .bit_sel(alu_bit),
    .flags_in(flags),
    .result(calc_result),
    .flags_out(calc_flags)
  );

  // Software flag ops take the cycle ahead of the calculator
  always_comb
  begin
    next_flags = flags;
    case (flag_op)
      LOAD_FLAGS_OP: next_flags = flag_operand;
      AND_FLAGS_OP: next_flags = flags & flag_operand;
      OR_FLAGS_OP: next_flags = flags | flag_operand;
      XOR_FLAGS_OP: next_flags = flags ^ flag_operand;
      // Store just reads condition_flags; only an enabled calculator changes them
      default:
        if (alu_en)
          next_flags = calc_flags;
    endcase
    // Interrupt entry sets the mask over any clear
    if (irq_start)
      next_flags[CF_MASK] = 1'b1;
  end

  // Flag register and result capture
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      flags <= FLAGS_RESET;
      alu_result <= 16'h0000;
    end
    else
    begin
      flags <= next_flags;
      if (alu_en)
        alu_result <= calc_result;
    end
  end
  assign condition_flags = flags;

  // Maskable requests pass only while the mask is clear
  assign irq_take = nmi_req | (irq_req & ~flags[CF_MASK]);

  // Branch condition from the four arithmetic flags
  wire logic f_n;
  wire logic f_z;
  wire logic f_v;
  wire logic f_c;
  wire logic f_nv;
  assign f_n = flags[CF_NEG];
  assign f_z = flags[CF_ZERO];
  assign f_v = flags[CF_OVF];
  assign f_c = flags[CF_CARRY];
  assign f_nv = f_n ^ f_v;

  // Condition decode
  always_comb
  begin
    case (cond_code)
      COND_ALWAYS: cond_true = 1'b1;
      COND_HI: cond_true = ~(f_c | f_z);
      COND_LS: cond_true = f_c | f_z;
      COND_CC: cond_true = ~f_c;
      COND_CS: cond_true = f_c;
      COND_NE: cond_true = ~f_z;
      COND_EQ: cond_true = f_z;
      COND_VC: cond_true = ~f_v;
      COND_VS: cond_true = f_v;
      COND_PL: cond_true = ~f_n;
      COND_MI: cond_true = f_n;
      COND_GE: cond_true = ~f_nv;
      COND_LT: cond_true = f_nv;
      COND_GT: cond_true = ~(f_z | f_nv);
      COND_LE: cond_true = f_z | f_nv;
      default: cond_true = 1'b0;
    endcase
  end

  // Helper terms for the checks below
  wire logic flag_write;
  wire logic alu_live;
  wire logic [8:0] add_chk;
  wire logic [4:0] add_half_chk;
  wire logic [12:0] word_half_chk;
  wire logic bit_pick;
  assign flag_write = flag_op inside {LOAD_FLAGS_OP, AND_FLAGS_OP,
    OR_FLAGS_OP, XOR_FLAGS_OP};
  assign alu_live = alu_en && !flag_write;
  assign add_chk = {1'b0, alu_a[7:0]} + {1'b0, alu_b[7:0]};
  assign add_half_chk = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
  assign word_half_chk = {1'b0, alu_a[11:0]} + {1'b0, alu_b[11:0]};
  assign bit_pick = alu_a[alu_bit];

  // Address read returns the whole word last written
  chk_addr_word: assert property
    (@(posedge clk) disable iff (sys_rst)
    (wr_en && wr_size == SZ_WORD && wr_sel != SP_INDEX)
    ##1 (!wr_en && addr_sel == $past(wr_sel))
    |=> addr_value == $past(wr_data, 2))
    else $error("address port lost part of the word");

  // A high-byte write keeps the low byte
  chk_byte_keep: assert property
    (@(posedge clk) disable iff (sys_rst)
    (wr_en && wr_size == SZ_HIGH) |=>
    gpr[$past(wr_sel)] == {$past(wr_data[7:0]), $past(wr_old[7:0])})
    else $error("byte write disturbed other half");

  // Push moves the stack pointer down one word
  chk_sp_push: assert property
    (@(posedge clk) disable iff (sys_rst)
    (sp_push && !sp_pop && !(wr_en && wr_sel == SP_INDEX)) |=>
    stack_top_pointer == $past(stack_top_pointer) - SP_STEP)
    else $error("stack push moved wrong amount");

  // Stepping advances one word, low bit stays clear
  chk_ip_step: assert property
    (@(posedge clk) disable iff (sys_rst)
    (ip_step && !ip_load) |=> instruction_pointer ==
    $past(instruction_pointer) + FETCH_BYTES &&
    !instruction_pointer[0])
    else $error("program counter step wrong");

  // Leaving reset: vector loaded, mask set
  chk_reset_load: assert property
    (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> instruction_pointer ==
    {$past(reset_vector[15:1]), 1'b0} &&
    condition_flags[CF_MASK])
    else $error("reset did not load vector and mask");

  // Masked requests blocked, non-maskable always passes
  chk_mask_block: assert property
    (@(posedge clk) disable iff (sys_rst)
    condition_flags[CF_MASK] |-> irq_take == nmi_req)
    else $error("masked interrupt got through");

  // Interrupt entry leaves the mask set for the handler
  chk_mask_entry: assert property
    (@(posedge clk) disable iff (sys_rst)
    irq_start |=> condition_flags[CF_MASK])
    else $error("mask not set on interrupt entry");

  // Calculator never touches the user bits or mask
  chk_user_keep: assert property
    (@(posedge clk) disable iff (sys_rst)
    (alu_live && !irq_start) |=> {condition_flags[CF_MASK:CF_USER_HI],
    condition_flags[CF_USER_LO]} == {$past(flags[CF_MASK:CF_USER_HI]),
    $past(flags[CF_USER_LO])})
    else $error("user bits changed by arithmetic");

  // Byte add: carry from bit 7, half-carry from bit 3, zero flag
  chk_byte_add: assert property
    (@(posedge clk) disable iff (sys_rst)
    (alu_live && alu_op == ALU_ADD_B) |=>
    condition_flags[CF_CARRY] == $past(add_chk[8]) &&
    condition_flags[CF_HALF] == $past(add_half_chk[4]) &&
    condition_flags[CF_ZERO] == (alu_result[7:0] == 8'h00) &&
    condition_flags[CF_NEG] == alu_result[7])
    else $error("byte add flags wrong");

  // Word add: half-carry from bit 11
  chk_word_half: assert property
    (@(posedge clk) disable iff (sys_rst)
    (alu_live && alu_op == ALU_ADD_W) |=>
    condition_flags[CF_HALF] == $past(word_half_chk[12]))
    else $error("word half-carry wrong");

  // Byte overflow: two positives giving a negative
  chk_ovf_add: assert property
    (@(posedge clk) disable iff (sys_rst)
    (alu_live && alu_op == ALU_ADD_B && !alu_a[7] && !alu_b[7]) |=>
    condition_flags[CF_OVF] == alu_result[7])
    else $error("overflow flag wrong");

  // Left shift drops the top bit into carry
  chk_shift_out: assert property
    (@(posedge clk) disable iff (sys_rst)
    (alu_live && alu_op == ALU_SHL_B) |=>
    condition_flags[CF_CARRY] == $past(alu_a[7]))
    else $error("shift carry wrong");

  // Bit load copies the indexed bit into carry
  chk_bit_load: assert property
    (@(posedge clk) disable iff (sys_rst)
    (alu_live && alu_op == BIT_LOAD) |=>
    condition_flags[CF_CARRY] == $past(bit_pick))
    else $error("bit load carry wrong");

  // The GE branch test follows N equal to V
  chk_branch_cond: assert property
    (@(posedge clk) disable iff (sys_rst)
    (cond_code == COND_GE) |-> cond_true ==
    (condition_flags[CF_NEG] == condition_flags[CF_OVF]))
    else $error("branch condition wrong");

  // Main scenarios
  cov_nmi_masked: cover property (@(posedge clk) disable iff (sys_rst)
    condition_flags[CF_MASK] && nmi_req && irq_req);
  cov_push_pop: cover property (@(posedge clk) disable iff (sys_rst)
    sp_push ##1 sp_pop);
  cov_decimal: cover property (@(posedge clk) disable iff (sys_rst)
    alu_live && alu_op == DECIMAL_ADJUST_ADD && alu_a[7:0] > BCD_LIMIT_B);
  cov_flag_load: cover property (@(posedge clk) disable iff (sys_rst)
    flag_op == LOAD_FLAGS_OP ##1 irq_start);
endmodule // cpurf_reg_file
`default_nettype wire

//--- verification/cpurf_reg_file_bench.sv
`timescale 1ns/10ps
`default_nettype none
module cpurf_reg_file_bench;
  import cpurf_pkg::*;
  // Stimulus toward the register file
  logic clk, sys_rst, we, push, pop, ipl, ips, irq, nmi, irs, aen;
  logic [2:0] asel, rsel, wsel, xbit;
  logic [15:0] vec, wd, ipv, xa, xb;
  cpurf_size_t rsz, wsz;
  cpurf_fop_t fop;
  cpurf_alu_t aop;
  cpurf_cond_t cc;
  logic [7:0] fopd;
  // Observed outputs
  logic [15:0] av, rdd, sp, ip, ar;
  logic [7:0] fl;
  logic take, ct;
  // Shadow state, built only from stimulus
  logic [15:0] gpr [8];
  logic [15:0] eip, s;
  logic [7:0] ef;
  logic [31:0] r;
  int fails = 0;
  int n_tests = 0;
  int seed = 32'hab6e2821;
  int i;
  // Tables of sizes and flag ops
  cpurf_size_t szt [3] = '{SZ_WORD, SZ_HIGH, SZ_LOW};
  cpurf_fop_t fot [5] = '{LOAD_FLAGS_OP, AND_FLAGS_OP, OR_FLAGS_OP,
    XOR_FLAGS_OP, STORE_FLAGS_OP};

  cpurf_reg_file i_dut
  (
    .clk(clk), .sys_rst(sys_rst), .reset_vector(vec),
    .addr_sel(asel), .addr_value(av), .rd_sel(rsel), .rd_size(rsz),
    .rd_data(rdd), .wr_en(we), .wr_sel(wsel), .wr_size(wsz),
    .wr_data(wd), .sp_push(push), .sp_pop(pop),
    .stack_top_pointer(sp), .ip_load(ipl), .ip_value(ipv),
    .ip_step(ips), .instruction_pointer(ip), .irq_req(irq),
    .nmi_req(nmi), .irq_start(irs), .irq_take(take),
    .flag_op(fop), .flag_operand(fopd), .condition_flags(fl),
    .alu_en(aen), .alu_op(aop), .alu_a(xa), .alu_b(xb),
    .alu_bit(xbit), .alu_result(ar), .cond_code(cc), .cond_true(ct)
  );

  // Free-running 4 ns clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard, far above the length of the run
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    final_report;
  end

  // Expected read data: bytes come back in the low lane
  function automatic logic [15:0] rexp(input logic [2:0] n,
    input cpurf_size_t z);
    if (z == SZ_HIGH)
      return {8'h00, gpr[n][15:8]};
    if (z == SZ_LOW)
      return {8'h00, gpr[n][7:0]};
    return gpr[n];
  endfunction

  // Expected flags after an add; mask and user bits kept
  function automatic logic [7:0] addf(input logic [15:0] x,
    input logic [15:0] y, input logic w, input logic [7:0] f);
    logic [16:0] t;
    logic [7:0] g;
    logic xs, ys, ts;
    t = w ? 17'(x) + 17'(y) : 17'(x[7:0]) + 17'(y[7:0]);
    g = f;
    g[CF_HALF] = w ? ((x & 16'h0FFF) + (y & 16'h0FFF)) >= 16'h1000
      : ((x & 16'h000F) + (y & 16'h000F)) >= 16'h0010;
    xs = w ? x[15] : x[7];
    ys = w ? y[15] : y[7];
    ts = w ? t[15] : t[7];
    g[CF_NEG] = ts;
    g[CF_ZERO] = w ? (t[15:0] == 16'h0000) : (t[7:0] == 8'h00);
    g[CF_OVF] = (xs == ys) && (ts != xs);
    g[CF_CARRY] = w ? t[16] : t[8];
    return g;
  endfunction

  // Expected branch outcome from the stored flags
  function automatic logic cexp(input cpurf_cond_t c, input logic [7:0] f);
    logic n, z, v, k;
    n = f[CF_NEG];
    z = f[CF_ZERO];
    v = f[CF_OVF];
    k = f[CF_CARRY];
    case (c)
      COND_ALWAYS: return 1'b1;
      COND_HI: return !(k || z);
      COND_LS: return k || z;
      COND_CC: return !k;
      COND_CS: return k;
      COND_NE: return !z;
      COND_EQ: return z;
      COND_VC: return !v;
      COND_VS: return v;
      COND_PL: return !n;
      COND_MI: return n;
      COND_GE: return n == v;
      COND_LT: return n != v;
      COND_GT: return !z && (n == v);
      COND_LE: return z || (n != v);
      default: return 1'b0;
    endcase
  endfunction

  task go;
    @(posedge clk);
  endtask

  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, g, e);
    end
  endtask

  task final_report;
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One-cycle write pulse, shadow merges byte halves
  task wr(input logic [2:0] n, input cpurf_size_t z,
    input logic [15:0] d);
    go;
    we <= 1'b1;
    wsel <= n;
    wsz <= z;
    wd <= d;
    go;
    we <= 1'b0;
    if (z == SZ_HIGH)
      gpr[n][15:8] = d[7:0];
    else if (z == SZ_LOW)
      gpr[n][7:0] = d[7:0];
    else
      gpr[n] = d;
  endtask

  // Data and address read of one register
  task rd(input logic [2:0] n, input cpurf_size_t z);
    go;
    rsel <= n;
    rsz <= z;
    asel <= n;
    go;
    #1;
    chk(rdd, rexp(n, z));
    chk(av, gpr[n]);
  endtask

  // Stack adjust; both at once is a no-op
  task spa(input logic u, input logic o);
    go;
    push <= u;
    pop <= o;
    go;
    push <= 1'b0;
    pop <= 1'b0;
    if (u ^ o)
      gpr[7] = u ? gpr[7] - SP_STEP : gpr[7] + SP_STEP;
    #1;
    chk(sp, gpr[7]);
  endtask

  // Program counter load or step, load wins
  task ipt(input logic l, input logic t, input logic [15:0] v);
    go;
    ipl <= l;
    ips <= t;
    ipv <= v;
    go;
    ipl <= 1'b0;
    ips <= 1'b0;
    if (l)
      eip = {v[15:1], 1'b0};
    else if (t)
      eip = eip + 16'h0002;
    #1;
    chk(ip, eip);
  endtask

  // Direct flag operation, optional interrupt entry alongside
  task fo(input cpurf_fop_t op, input logic [7:0] d, input logic e);
    go;
    fop <= op;
    fopd <= d;
    irs <= e;
    go;
    fop <= FLAGS_IDLE;
    irs <= 1'b0;
    case (op)
      LOAD_FLAGS_OP: ef = d;
      AND_FLAGS_OP: ef = ef & d;
      OR_FLAGS_OP: ef = ef | d;
      XOR_FLAGS_OP: ef = ef ^ d;
      default: ef = ef;
    endcase
    ef[CF_MASK] = ef[CF_MASK] | e;
    #1;
    chk({8'h00, fl}, {8'h00, ef});
  endtask

  // One flag-producing operation
  task alu(input cpurf_alu_t op, input logic [15:0] x,
    input logic [15:0] y, input logic [2:0] n);
    go;
    aen <= 1'b1;
    aop <= op;
    xa <= x;
    xb <= y;
    xbit <= n;
    go;
    aen <= 1'b0;
    #1;
  endtask

  // Byte or word add against the flag model
  task addc(input logic w, input logic [15:0] x, input logic [15:0] y);
    if (!w)
    begin
      x = x & 16'h00FF;
      y = y & 16'h00FF;
    end
    alu(w ? ALU_ADD_W : ALU_ADD_B, x, y, 3'h0);
    s = x + y;
    ef = addf(x, y, w, ef);
    chk(w ? ar : {8'h00, ar[7:0]}, w ? s : {8'h00, s[7:0]});
    chk({8'h00, fl}, {8'h00, ef});
  endtask

  initial
  begin
    sys_rst = 1'b1;
    {we, push, pop, ipl, ips, irq, nmi, irs, aen} = '0;
    {asel, rsel, wsel, xbit} = '0;
    {wd, ipv, xa, xb} = '0;
    rsz = SZ_WORD;
    wsz = SZ_WORD;
    fop = FLAGS_IDLE;
    aop = ALU_ADD_B;
    cc = COND_ALWAYS;
    fopd = 8'h00;
    vec = 16'($random(seed)) | 16'h0001;
    repeat (16) go;
    sys_rst <= 1'b0;
    #1;
    eip = {vec[15:1], 1'b0};
    ef = 8'h80;
    chk(ip, eip);
    chk({8'h00, fl}, 16'h0080);
    for (i = 0; i < 8; i++)
      wr(i[2:0], SZ_WORD, 16'($random(seed)));
    wr(3, SZ_WORD, 16'hA55A);
    wr(3, SZ_HIGH, 16'h00C3);
    wr(3, SZ_LOW, 16'h0011);
    rd(3, SZ_WORD);
    for (i = 0; i < 40; i++)
    begin
      r = $random(seed);
      wr(r[2:0], szt[r[5:4] % 3], r[31:16]);
      rd(r[10:8], szt[r[13:12] % 3]);
    end
    wr(7, SZ_WORD, 16'h0002);
    spa(1, 0);
    spa(1, 0);
    spa(0, 1);
    spa(1, 1);
    rd(7, SZ_WORD);
    ipt(1, 0, 16'h1235);
    ipt(0, 1, 16'h0000);
    ipt(1, 1, 16'hFFFF);
    ipt(0, 1, 16'h0000);
    for (i = 0; i < 8; i++)
    begin
      r = $random(seed);
      ipt(r[0], r[1], r[31:16]);
    end
    fo(LOAD_FLAGS_OP, 8'h00, 1'b1);
    for (i = 0; i < 24; i++)
    begin
      r = $random(seed);
      fo(fot[r[10:8] % 5], r[7:0], r[11] & r[12]);
      irq <= r[13];
      nmi <= r[14];
      cc <= cpurf_cond_t'(r[18:15]);
      #1;
      chk(take, r[14] | (r[13] & ~ef[CF_MASK]));
      chk(ct, cexp(cpurf_cond_t'(r[18:15]), ef));
    end
    addc(0, 16'h000F, 16'h0001);
    addc(0, 16'h007F, 16'h0001);
    addc(0, 16'h00FF, 16'h0001);
    addc(1, 16'h0FFF, 16'h0001);
    addc(1, 16'h8000, 16'h8000);
    for (i = 0; i < 24; i++)
    begin
      r = $random(seed);
      addc(r[0], r[31:16], 16'($random(seed)));
    end
    alu(ALU_SHL_B, 16'h0080, 16'h0000, 3'h0);
    chk(fl[CF_CARRY], 1'b1);
    alu(ALU_SHR_B, 16'h0001, 16'h0000, 3'h0);
    chk(fl[CF_CARRY], 1'b1);
    alu(ALU_SHL_B, 16'h0040, 16'h0000, 3'h0);
    chk(fl[CF_CARRY], 1'b0);
    for (i = 0; i < 8; i++)
    begin
      r = $random(seed);
      alu(BIT_LOAD, {8'h00, r[7:0]}, 16'h0000, i[2:0]);
      chk(fl[CF_CARRY], r[i]);
    end
    // Byte subtract borrowing through both nibbles
    alu(ALU_SUB_B, 16'h0010, 16'h0011, 3'h0);
    chk({8'h00, ar[7:0]}, 16'h00FF);
    chk({fl[CF_HALF], fl[CF_CARRY]}, 2'b11);
    // Packed decimal sums corrected digit by digit
    addc(0, 16'h0015, 16'h0027);
    alu(DECIMAL_ADJUST_ADD, s, 16'h0000, 3'h0);
    chk(ar, 16'h0042);
    addc(0, 16'h0019, 16'h0028);
    alu(DECIMAL_ADJUST_ADD, s, 16'h0000, 3'h0);
    chk(ar, 16'h0047);
    addc(0, 16'h0099, 16'h0001);
    alu(DECIMAL_ADJUST_ADD, s, 16'h0000, 3'h0);
    chk({ar[7:0], 7'h00, fl[CF_CARRY]}, 16'h0001);
    final_report;
  end
endmodule // cpurf_reg_file_bench
`default_nettype wire
